// *** include/hib_pkg.sv ***
// Constants, register map and carrier types of the hibernation controller
package hib_pkg;

    // ------------------------------------------------------------
    // Bus and register map
    // ------------------------------------------------------------
    localparam int unsigned ADDR_W = 12;
    localparam int unsigned DATA_W = 32;
    localparam logic [11:0] OFF_CTL = 12'h000;
    localparam logic [11:0] OFF_COUNT = 12'h004;
    localparam logic [11:0] OFF_MATCH0 = 12'h008;
    localparam logic [11:0] OFF_MATCH1 = 12'h00C;
    localparam logic [11:0] OFF_RAW = 12'h010;
    localparam logic [11:0] OFF_FILT = 12'h014;
    localparam logic [11:0] OFF_IEN = 12'h018;
    localparam logic [11:0] OFF_ICLR = 12'h01C;

    // ------------------------------------------------------------
    // Interrupt status layout (raw, filtered, enable, clear)
    // ------------------------------------------------------------
    localparam int unsigned INT_W = 4;
    localparam int unsigned INT_PIN = 0;
    localparam int unsigned INT_LOWBAT = 1;
    localparam int unsigned INT_MATCH0 = 2;
    localparam int unsigned INT_MATCH1 = 3;
    localparam logic [3:0] IEN_RESET = 4'h0;

    // ------------------------------------------------------------
    // Control register layout
    // ------------------------------------------------------------
    localparam int unsigned CTL_W = 7;
    localparam int unsigned CTL_HIB_BIT = 2;
    localparam int unsigned CTL_BATLOW_BIT = 7;
    localparam logic [6:0] CTL_RESET = 7'h00;

    typedef enum logic [1:0] {
        BAT_OFF = 2'b00,
        BATTERY_SENSE_ONLY = 2'b01,
        BAT_RESERVED = 2'b10,
        BATTERY_SENSE_CANCEL_SLEEP = 2'b11
    } lowbat_mode_t;

    typedef struct packed {
        lowbat_mode_t lowbat;
        logic wake_rtc;
        logic wake_pin;
        logic hib_req;
        logic rtc_en;
        logic active;
    } ctl_t;

    typedef struct packed {
        logic [11:0] addr;
        logic write;
        logic [31:0] wdata;
    } apb_req_t;

    // ------------------------------------------------------------
    // Power state and time base
    // ------------------------------------------------------------
    typedef enum logic [0:0] {
        PWR_ON = 1'b0,
        PWR_OFF = 1'b1
    } pwr_state_t;

    localparam longint unsigned CLK_HZ = 40000000;
    localparam longint unsigned TICK_PERIOD_S = 1;
    localparam int unsigned TICK_CYCLES = int'(CLK_HZ * TICK_PERIOD_S);
    localparam int unsigned DIV_W = 26;

endpackage

// *** design/hib_power_ctl.sv ***
// Hibernation power controller with seconds counter and APB registers
//
// What this block does
// [R1] Interrupt status readable raw or enable-filtered, chosen by address.
// [R2] Control register shows an active bit that survives processor resets.
// [R3] With sensing on, low battery sets raw status and may interrupt.
// [R4] In cancel-sleep mode a low battery makes sleep requests ignored.
// [R5] Battery mode is sense-only or sense-and-cancel, and reads back.
// [R6] A sleep request drops regulator enable; controller keeps running.
// [R7] While asleep any enabled wake condition raises regulator enable.
// [R8] Processor reset after wake leaves this block's state intact.
// [R9] Software sets wake sources first and tolerates running on.
// [R10] Counter has an enable; disabled means no counting, match or wake.
// [R11] Clearing the enable halts counting and match until re-enabled.
// [R12] Counter value is readable at any time.
// [R13] Match 0 register read/write; equality raises status and/or wake.
// [R14] Each of pin, battery, match 0, match 1 has an enable bit.
// [R15] Writing a mask clears only the selected status bits.
// [R16] Counter steps once per second and software may load it.
// [R17] Filtered status is raw AND enable; interrupt while any is set.
`timescale 1ns/10ps
module hib_power_ctl #(
    parameter int unsigned TICK_CYCLES = hib_pkg::TICK_CYCLES
) (
    // Clock and always-on reset
    input wire logic pclk,
    input wire logic presetn,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Board side
    input wire logic wake_pin,
    input wire logic battery_low,
    output logic regulator_en,
    output logic irq
);

    // ------------------------------------------------------------
    // Bus decode
    // ------------------------------------------------------------
    function automatic logic hit(input logic [11:0] a,
                                 input logic [11:0] off);
        hit = (a == off);
    endfunction

    hib_pkg::apb_req_t req;
    logic setup;
    logic wr_en;
    logic mapped;
    logic filtered_status_select;
    assign req = '{addr: paddr, write: pwrite, wdata: pwdata};
    assign setup = psel & ~penable;
    // Writes land at the access edge; zero wait states
    assign wr_en = psel & penable & req.write;
    assign mapped = hit(req.addr, hib_pkg::OFF_CTL) |
                    hit(req.addr, hib_pkg::OFF_COUNT) |
                    hit(req.addr, hib_pkg::OFF_MATCH0) |
                    hit(req.addr, hib_pkg::OFF_MATCH1) |
                    hit(req.addr, hib_pkg::OFF_RAW) |
                    hit(req.addr, hib_pkg::OFF_FILT) |
                    hit(req.addr, hib_pkg::OFF_IEN) |
                    hit(req.addr, hib_pkg::OFF_ICLR);
    // [R1] raw or filtered view
    assign filtered_status_select = hit(req.addr, hib_pkg::OFF_FILT);
    assign pready = 1'b1;

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    hib_pkg::ctl_t ctl_q;
    hib_pkg::pwr_state_t pwr_q;
    logic [31:0] count_q;
    logic [31:0] match0_q;
    logic [31:0] match1_q;
    logic [25:0] div_q;
    logic [3:0] raw_q;
    logic [3:0] ien_q;
    logic [3:0] filt;
    logic [3:0] set_ev;
    logic [3:0] clr_mask;
    logic eq0_q;
    logic eq1_q;
    logic pin_q;
    logic tick;
    logic bat_sense;
    logic bat_cancel;
    logic hib_go;
    logic wake_ev;
    logic [31:0] rdata_q;
    logic err_q;

    // [R5] battery mode decode
    assign bat_sense = ctl_q.lowbat[0];
    assign bat_cancel = (ctl_q.lowbat == hib_pkg::BATTERY_SENSE_CANCEL_SLEEP);

    // ------------------------------------------------------------
    // Control register
    // ------------------------------------------------------------
    // Only presetn clears this; it is the battery-backed reset, so a
    // processor power-on reset after wake leaves it alone.
    // [R2] active bit persists
    // [R8] held across processor reset
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctl_q <= hib_pkg::CTL_RESET;
        end else if (wr_en && hit(req.addr, hib_pkg::OFF_CTL)) begin
            ctl_q <= req.wdata[hib_pkg::CTL_W-1:0];
            ctl_q.hib_req <= 1'b0;
        end
    end

    // Request accepted only when running, active and not cancelled
    // [R4] low battery cancels sleep
    assign hib_go = wr_en && hit(req.addr, hib_pkg::OFF_CTL) &&
                    req.wdata[hib_pkg::CTL_HIB_BIT] && ctl_q.active &&
                    (pwr_q == hib_pkg::PWR_ON) &&
                    !(bat_cancel && battery_low);

    // Wake sources; counter wake needs the counter enabled
    // [R7] any enabled wake condition
    assign wake_ev = (ctl_q.wake_pin && wake_pin) ||
                     (ctl_q.wake_rtc && ctl_q.rtc_en &&
                      (set_ev[hib_pkg::INT_MATCH0] ||
                       set_ev[hib_pkg::INT_MATCH1]));

    // ------------------------------------------------------------
    // Power sequencer
    // ------------------------------------------------------------
    // [R6] drop regulator on request
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pwr_q <= hib_pkg::PWR_ON;
        end else begin
            case (pwr_q)
                hib_pkg::PWR_ON: begin
                    if (hib_go) begin
                        pwr_q <= hib_pkg::PWR_OFF;
                    end
                end
                hib_pkg::PWR_OFF: begin
                    if (wake_ev) begin
                        pwr_q <= hib_pkg::PWR_ON;
                    end
                end
                default: pwr_q <= hib_pkg::PWR_ON;
            endcase
        end
    end
    assign regulator_en = (pwr_q == hib_pkg::PWR_ON);

    // ------------------------------------------------------------
    // Seconds divider and counter
    // ------------------------------------------------------------
    // Divider restarts on a load so the first step is a full second
    // [R16] one step per second
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            div_q <= '0;
        end else if (!ctl_q.rtc_en ||
                     (wr_en && hit(req.addr, hib_pkg::OFF_COUNT))) begin
            div_q <= '0;
        end else if (tick) begin
            div_q <= '0;
        end else begin
            div_q <= div_q + 26'h0000001;
        end
    end
    assign tick = ctl_q.rtc_en &&
                  (div_q == 26'(TICK_CYCLES - 1));

    // Loads are refused while disabled, like counting, match and wake
    // [R10] counter needs enable
    // [R11] disable halts counting
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            count_q <= '0;
        end else if (ctl_q.rtc_en &&
                     wr_en && hit(req.addr, hib_pkg::OFF_COUNT)) begin
            count_q <= req.wdata;
        end else if (tick) begin
            count_q <= count_q + 32'h00000001;
        end
    end

    // Match registers
    // [R13] match 0 read/write
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            match0_q <= '0;
            match1_q <= '0;
        end else if (wr_en) begin
            if (hit(req.addr, hib_pkg::OFF_MATCH0)) begin
                match0_q <= req.wdata;
            end
            if (hit(req.addr, hib_pkg::OFF_MATCH1)) begin
                match1_q <= req.wdata;
            end
        end
    end

    // Edge of equality, so a cleared match bit does not refire at once
    // [R13] equality event
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            eq0_q <= 1'b0;
            eq1_q <= 1'b0;
            pin_q <= 1'b0;
        end else begin
            eq0_q <= ctl_q.rtc_en && (count_q == match0_q);
            eq1_q <= ctl_q.rtc_en && (count_q == match1_q);
            pin_q <= wake_pin;
        end
    end

    // ------------------------------------------------------------
    // Interrupt status
    // ------------------------------------------------------------
    // [R3] low battery to raw status
    // [R11] match events need enable
    always_comb begin
        set_ev = '0;
        set_ev[hib_pkg::INT_PIN] = wake_pin && !pin_q;
        set_ev[hib_pkg::INT_LOWBAT] = bat_sense && battery_low;
        set_ev[hib_pkg::INT_MATCH0] = ctl_q.rtc_en &&
            (count_q == match0_q) && !eq0_q;
        set_ev[hib_pkg::INT_MATCH1] = ctl_q.rtc_en &&
            (count_q == match1_q) && !eq1_q;
    end

    assign clr_mask = (wr_en && hit(req.addr, hib_pkg::OFF_ICLR)) ?
                      req.wdata[hib_pkg::INT_W-1:0] : '0;

    // Sticky bits; a set in the clearing cycle wins
    // [R15] mask clear
    generate
        for (genvar i = 0; i < hib_pkg::INT_W; i++) begin : g_sticky
            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    raw_q[i] <= 1'b0;
                end else if (set_ev[i]) begin
                    raw_q[i] <= 1'b1;
                end else if (clr_mask[i]) begin
                    raw_q[i] <= 1'b0;
                end
            end
        end
    endgenerate

    // [R14] per-source enable
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ien_q <= hib_pkg::IEN_RESET;
        end else if (wr_en && hit(req.addr, hib_pkg::OFF_IEN)) begin
            ien_q <= req.wdata[hib_pkg::INT_W-1:0];
        end
    end

    // [R17] filtered status and line
    assign filt = raw_q & ien_q;
    assign irq = |filt;

    // ------------------------------------------------------------
    // Read data, captured in the setup cycle
    // ------------------------------------------------------------
    // [R12] counter readable
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rdata_q <= '0;
            err_q <= 1'b0;
        end else if (setup) begin
            err_q <= !mapped;
            rdata_q <= '0;
            if (!req.write) begin
                case (req.addr)
                    hib_pkg::OFF_CTL: begin
                        rdata_q[hib_pkg::CTL_W-1:0] <= ctl_q;
                        rdata_q[hib_pkg::CTL_HIB_BIT] <=
                            (pwr_q == hib_pkg::PWR_OFF);
                        rdata_q[hib_pkg::CTL_BATLOW_BIT] <= battery_low;
                    end
                    hib_pkg::OFF_COUNT: rdata_q <= count_q;
                    hib_pkg::OFF_MATCH0: rdata_q <= match0_q;
                    hib_pkg::OFF_MATCH1: rdata_q <= match1_q;
                    hib_pkg::OFF_RAW: begin
                        rdata_q[hib_pkg::INT_W-1:0] <= raw_q;
                    end
                    hib_pkg::OFF_FILT: begin
                        rdata_q[hib_pkg::INT_W-1:0] <= filt;
                    end
                    hib_pkg::OFF_IEN: begin
                        rdata_q[hib_pkg::INT_W-1:0] <= ien_q;
                    end
                    default: rdata_q <= '0;
                endcase
            end
        end
    end
    assign prdata = rdata_q;
    assign pslverr = psel & penable & err_q;

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    property p_filt_read;
        setup && !pwrite && filtered_status_select ##1 penable
            |-> prdata[3:0] == $past(raw_q & ien_q);
    endproperty
    a_filt_read: assert property (p_filt_read) // [R1]
        else $error("filtered status read wrong");

    property p_active_keep;
        ctl_q.active && !(wr_en && hit(paddr, hib_pkg::OFF_CTL))
            |=> ctl_q.active;
    endproperty
    a_active_keep: assert property (p_active_keep) // [R2]
        else $error("active bit lost");

    property p_lowbat;
        bat_sense && battery_low |=> raw_q[hib_pkg::INT_LOWBAT];
    endproperty
    a_lowbat: assert property (p_lowbat) // [R3]
        else $error("low battery not flagged");

    property p_cancel;
        regulator_en && bat_cancel && battery_low |=> regulator_en;
    endproperty
    a_cancel: assert property (p_cancel) // [R4]
        else $error("sleep not cancelled on low battery");

    property p_sleep;
        hib_go |=> !regulator_en;
    endproperty
    a_sleep: assert property (p_sleep) // [R6]
        else $error("regulator still on after request");

    property p_wake;
        !regulator_en && ctl_q.wake_pin && wake_pin |=> regulator_en;
    endproperty
    a_wake: assert property (p_wake) // [R7]
        else $error("no wake on pin");

    property p_halt;
        !ctl_q.rtc_en ##1 !ctl_q.rtc_en |-> $stable(count_q);
    endproperty
    a_halt: assert property (p_halt) // [R11]
        else $error("counter moved while disabled");

    property p_step;
        tick && !(wr_en && hit(paddr, hib_pkg::OFF_COUNT))
            |=> count_q == $past(count_q) + 32'h00000001;
    endproperty
    a_step: assert property (p_step) // [R16]
        else $error("counter did not step");

    property p_match;
        ctl_q.rtc_en && count_q == match0_q && !eq0_q
            |=> raw_q[hib_pkg::INT_MATCH0];
    endproperty
    a_match: assert property (p_match) // [R13]
        else $error("match 0 not flagged");

    property p_clear;
        clr_mask[0] && !set_ev[0] |=> !raw_q[0];
    endproperty
    a_clear: assert property (p_clear) // [R15]
        else $error("status bit not cleared");

    // Enabled event must reach the line through its sticky bit
    property p_irq;
        (set_ev & ien_q) != 4'h0 &&
            !(wr_en && hit(paddr, hib_pkg::OFF_IEN)) |=> irq;
    endproperty
    a_irq: assert property (p_irq) // [R17]
        else $error("interrupt line mismatch");

    c_sleep_wake: cover property (!regulator_en ##[1:1000] regulator_en);
    c_cancel: cover property (wr_en && req.wdata[2] && bat_cancel &&
                              battery_low && ctl_q.active);
    c_match_irq: cover property (raw_q[hib_pkg::INT_MATCH0] && irq);

endmodule

// *** tb/hib_board_model.sv ***
// Board-side model: wake button, battery comparator and regulator
`timescale 1ns/10ps
module hib_board_model (
    // Clock and always-on reset
    input wire logic pclk,
    input wire logic presetn,
    // Bench commands
    input wire logic press_cmd,
    input wire logic weak_cmd,
    // Controller side
    input wire logic regulator_en,
    output logic wake_pin,
    output logic battery_low,
    output logic cpu_powered
);
    // --------------------------------------------------------
    // Pins
    // --------------------------------------------------------
    // Pins are retimed to pclk, as the controller expects them synchronous
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wake_pin <= 1'b0;
            battery_low <= 1'b0;
        end else begin
            wake_pin <= press_cmd;
            battery_low <= weak_cmd;
        end
    end

    // Supply rail lags the enable by one cycle, like a slow regulator
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cpu_powered <= 1'b1;
        end else begin
            cpu_powered <= regulator_en;
        end
    end
endmodule

// *** tb/tb_top.sv ***
// Self-checking bench for the hibernation power controller
`timescale 1ns/10ps
module tb_top;
    // --------------------------------------------------------
    // Signals
    // --------------------------------------------------------
    localparam logic [31:0] ALL = 32'hFFFFFFFF;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h00000000;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic wake_pin;
    logic battery_low;
    logic regulator_en;
    logic irq;
    logic cpu_powered;
    logic press_cmd = 1'b0;
    logic weak_cmd = 1'b0;
    logic [31:0] rd;
    logic [31:0] rd2;
    logic er;
    int err_count = 0;
    int cmp_count = 0;
    int cycles = 0;

    // 40 MHz clock
    always #12.5 pclk = ~pclk;

    // Short second so the counter moves within a short run
    hib_power_ctl #(.TICK_CYCLES(8)) i_dut (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .wake_pin(wake_pin), .battery_low(battery_low),
        .regulator_en(regulator_en), .irq(irq)
    );

    hib_board_model i_board (
        .pclk(pclk), .presetn(presetn), .press_cmd(press_cmd),
        .weak_cmd(weak_cmd), .regulator_en(regulator_en),
        .wake_pin(wake_pin), .battery_low(battery_low),
        .cpu_powered(cpu_powered)
    );

    // --------------------------------------------------------
    // Tasks
    // --------------------------------------------------------
    // Verdict and end of run
    task results;
        if (err_count == 0 && cmp_count > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    // Hang guard, well above the few hundred cycles the tests need
    always @(posedge pclk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            err_count = err_count + 1;
            results();
        end
    end

    task chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
            err_count++;
        end
    endtask

    // One APB transfer; request held until pready is seen high
    task xfer(input logic [11:0] a, input logic w, input logic [31:0] wd);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        paddr <= a;
        pwrite <= w;
        pwdata <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        // Only the hang guard may end a wait for the slave
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task wr(input logic [11:0] a, input logic [31:0] d);
        xfer(a, 1'b1, d);
    endtask

    task rchk(input logic [11:0] a, input logic [31:0] e,
              input logic [31:0] m);
        xfer(a, 1'b0, 32'h00000000);
        chk(rd & m, e);
    endtask

    task cyc(input int n);
        repeat (n) @(posedge pclk);
    endtask

    // Bounded wait for the rail to come back
    task wait_pwr;
        int n;
        n = 0;
        while (cpu_powered !== 1'b1 && n < 60) begin
            @(posedge pclk);
            n++;
        end
    endtask

    // --------------------------------------------------------
    // Test sequence
    // --------------------------------------------------------
    initial begin
        cyc(16);
        presetn <= 1'b1;
        // Reset state and register map
        chk(regulator_en, 32'h1);
        chk(irq, 32'h0);
        rchk(hib_pkg::OFF_CTL, 32'h00000000, ALL);
        rchk(hib_pkg::OFF_ICLR, 32'h00000000, ALL);
        wr(hib_pkg::OFF_IEN, 32'h0000000F);
        rchk(hib_pkg::OFF_IEN, 32'h0000000F, ALL);
        wr(hib_pkg::OFF_IEN, 32'h00000000);
        xfer(12'h020, 1'b0, 32'h00000000);
        chk(er, 32'h1);
        chk(rd, 32'h00000000);
        // Counter runs once enabled and stops when disabled
        wr(hib_pkg::OFF_CTL, 32'h00000003);
        rchk(hib_pkg::OFF_CTL, 32'h00000003, ALL);
        wr(hib_pkg::OFF_COUNT, 32'h00000010);
        xfer(hib_pkg::OFF_COUNT, 1'b0, 32'h00000000);
        rd2 = rd;
        chk(rd2, 32'h00000010);
        cyc(77);
        xfer(hib_pkg::OFF_COUNT, 1'b0, 32'h00000000);
        chk(rd - rd2, 32'h0000000A);
        wr(hib_pkg::OFF_CTL, 32'h00000001);
        xfer(hib_pkg::OFF_COUNT, 1'b0, 32'h00000000);
        rd2 = rd;
        cyc(77);
        xfer(hib_pkg::OFF_COUNT, 1'b0, 32'h00000000);
        chk(rd, rd2);
        // Match 0 event, pin event, raw versus filtered, selective clear
        wr(hib_pkg::OFF_CTL, 32'h00000003);
        wr(hib_pkg::OFF_MATCH0, 32'h00000007);
        rchk(hib_pkg::OFF_MATCH0, 32'h00000007, ALL);
        wr(hib_pkg::OFF_MATCH1, 32'h0000ABCD);
        rchk(hib_pkg::OFF_MATCH1, 32'h0000ABCD, ALL);
        wr(hib_pkg::OFF_COUNT, 32'h00000005);
        wr(hib_pkg::OFF_ICLR, 32'h0000000F);
        wr(hib_pkg::OFF_IEN, 32'h00000004);
        cyc(40);
        press_cmd <= 1'b1;
        cyc(3);
        press_cmd <= 1'b0;
        cyc(3);
        rchk(hib_pkg::OFF_RAW, 32'h00000005, ALL);
        chk(irq, 32'h1);
        rchk(hib_pkg::OFF_FILT, 32'h00000004, ALL);
        wr(hib_pkg::OFF_ICLR, 32'h00000004);
        rchk(hib_pkg::OFF_RAW, 32'h00000001, ALL);
        chk(irq, 32'h0);
        wr(hib_pkg::OFF_ICLR, 32'h00000001);
        rchk(hib_pkg::OFF_RAW, 32'h00000000, ALL);
        // Low battery in sense-only mode
        wr(hib_pkg::OFF_CTL, 32'h00000023);
        weak_cmd <= 1'b1;
        cyc(3);
        rchk(hib_pkg::OFF_CTL, 32'h000000A3, ALL);
        rchk(hib_pkg::OFF_RAW, 32'h00000002, ALL);
        wr(hib_pkg::OFF_IEN, 32'h00000002);
        rchk(hib_pkg::OFF_FILT, 32'h00000002, ALL);
        chk(irq, 32'h1);
        wr(hib_pkg::OFF_IEN, 32'h00000004);
        rchk(hib_pkg::OFF_FILT, 32'h00000000, ALL);
        chk(irq, 32'h0);
        // Cancel mode refuses sleep while the battery is low
        wr(hib_pkg::OFF_CTL, 32'h0000006B);
        wr(hib_pkg::OFF_CTL, 32'h0000006F);
        cyc(4);
        chk(regulator_en, 32'h1);
        rchk(hib_pkg::OFF_CTL, 32'h000000EB, ALL);
        // Sleep accepted with a good battery, pin wakes it
        weak_cmd <= 1'b0;
        cyc(3);
        wr(hib_pkg::OFF_ICLR, 32'h0000000F);
        wr(hib_pkg::OFF_CTL, 32'h0000006F);
        cyc(2);
        chk(regulator_en, 32'h0);
        chk(cpu_powered, 32'h0);
        rchk(hib_pkg::OFF_CTL, 32'h0000006F, ALL);
        press_cmd <= 1'b1;
        wait_pwr();
        press_cmd <= 1'b0;
        chk(cpu_powered, 32'h1);
        rchk(hib_pkg::OFF_CTL, 32'h0000006B, ALL);
        rchk(hib_pkg::OFF_RAW, 32'h00000001, 32'h00000001);
        // Counter match wakes from sleep
        wr(hib_pkg::OFF_CTL, 32'h00000013);
        wr(hib_pkg::OFF_MATCH0, 32'h00000022);
        wr(hib_pkg::OFF_COUNT, 32'h00000020);
        wr(hib_pkg::OFF_CTL, 32'h00000017);
        cyc(2);
        chk(regulator_en, 32'h0);
        wait_pwr();
        chk(cpu_powered, 32'h1);
        rchk(hib_pkg::OFF_RAW, 32'h00000004, 32'h00000004);
        results();
    end
endmodule
